// ==== verilog/uav_pkg.sv ====
// Purpose: constants for the two-line interrupt autovector block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: pending slots are indexed by priority minus one
// Summary of operation
// - usb sources get fixed priorities; vector is four times priority minus one
// - frame start 04, suspend 0C, bus reset 10, high speed 14
// - setup data 00, setup token 08, control handshake acked 18
// - ep0/ep1 in ready 20/28, out data 24/2C
// - endpoints 2,4,6,8 buffer events use vectors 30 to 3C
// - any in endpoint nak on bulk in raises vector 40
// - ping nak on ep 0,1,2,4,6,8 uses vectors 48 to 5C
// - bus error count above programmed limit raises vector 60
// - iso out pid sequence error on ep 2,4,6,8 uses 70 to 7C
// - usb autovector on: fetch at 0045 returns usb vector code
// - usb interrupt enters at 0043, where a jump instruction sits
// - fifo line shares 14 sources, vectors 80 to B4, priority 1 highest
// - programmable level flags of ep 2,4,6,8 use 80 to 8C
// - empty flags of ep 2,4,6,8 use 90 to 9C
// - full flags of ep 2,4,6,8 use A0 to AC
// - waveform engine done at priority 13, wait at 14 with B4
// - fifo autovector on: fetch at 0055 returns fifo vector code
// - fifo interrupt enters at 0053, where a jump instruction sits
package uav_pkg;
  localparam int USB_SLOTS = 32;
  localparam int FIFO_SLOTS = 14;
  // slots with no source: priorities 8, 18, 26, 27, 28
  localparam logic [31:0] USB_VALID_MASK = 32'hF1FD_FF7F;
  localparam logic [7:0] FIFO_VEC_BASE = 8'h80;
  // register byte offsets
  localparam logic [7:0] OFS_SETUP = 8'h00;
  localparam logic [7:0] OFS_USB_PEND = 8'h04;
  localparam logic [7:0] OFS_USB_EN = 8'h08;
  localparam logic [7:0] OFS_FIFO_PEND = 8'h0C;
  localparam logic [7:0] OFS_FIFO_EN = 8'h10;
  localparam logic [7:0] OFS_VECTORS = 8'h14;
  localparam logic [7:0] OFS_ERR_LIMIT = 8'h18;
  // field positions
  localparam int BIT_USB_AV = 0;
  localparam int BIT_FIFO_AV = 1;
  localparam int POS_FIFO_VEC = 8;
  localparam int POS_ERR_COUNT = 8;
  localparam int ERR_W = 4;
  // reset values
  localparam logic [1:0] RST_SETUP = 2'h0;
  localparam logic [31:0] RST_USB_EN = 32'h0000_0000;
  localparam logic [13:0] RST_FIFO_EN = 14'h0000;
  localparam logic [3:0] RST_ERR_LIMIT = 4'h4;
  // code space addresses
  localparam logic [15:0] ADDR_USB_ENTRY = 16'h0043;
  localparam logic [15:0] ADDR_USB_PAGE = 16'h0044;
  localparam logic [15:0] ADDR_USB_VEC = 16'h0045;
  localparam logic [15:0] ADDR_FIFO_ENTRY = 16'h0053;
  localparam logic [15:0] ADDR_FIFO_PAGE = 16'h0054;
  localparam logic [15:0] ADDR_FIFO_VEC = 16'h0055;
  // slot indices on the usb line (priority minus one)
  localparam int U_SETUP_DATA = 0;
  localparam int U_SOF = 1;
  localparam int U_SETUP_TOK = 2;
  localparam int U_SUSP = 3;
  localparam int U_URES = 4;
  localparam int U_HSPD = 5;
  localparam int U_ACK = 6;
  localparam int U_EP01 = 8;
  localparam int U_EPBUF = 12;
  localparam int U_BULK_NAK = 16;
  localparam int U_PING = 18;
  localparam int U_ERRLIM = 24;
  localparam int U_ISO = 28;
  // slot indices on the fifo line
  localparam int F_PF = 0;
  localparam int F_EF = 4;
  localparam int F_FF = 8;
  localparam int F_DONE = 12;
  localparam int F_WAIT = 13;
endpackage

// ==== verilog/uav_autovector.sv ====
// Purpose: second-level vectoring of the usb and fifo interrupt lines
// Assumes: event inputs are one-cycle pulses synchronous to mclk
// Notes: apb slave with zero wait states; vector fetch answer is registered
`timescale 1ns/100ps
module uav_autovector (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // usb line event pulses
  input wire logic setupDataReady,
  input wire logic frameStart,
  input wire logic setupTokenSeen,
  input wire logic suspendRequest,
  input wire logic busReset,
  input wire logic highSpeedEntered,
  input wire logic controlHandshakeAcked,
  input wire logic [1:0] epInReady,
  input wire logic [1:0] epOutHasData,
  input wire logic [3:0] epBufferEvent,
  input wire logic inBulkNak,
  input wire logic [5:0] pingNak,
  input wire logic busError,
  input wire logic [3:0] isoPidSequenceError,
  // fifo line event pulses
  input wire logic [3:0] programmableLevelFlag,
  input wire logic [3:0] bufferEmptyFlag,
  input wire logic [3:0] bufferFullFlag,
  input wire logic waveformEngineDone,
  input wire logic waveformEngineWait,
  // processor code fetch path
  input wire logic codeFetch,
  input wire logic [15:0] codeAddr,
  input wire logic [7:0] memData,
  output logic [7:0] fetchData,
  // to the processor
  output logic usbInterruptLine,
  output logic fifoInterruptLine,
  output logic [7:0] usbVectorCode,
  output logic [7:0] fifoVectorCode
);
  import uav_pkg::*;

  logic [1:0] setup_r;
  logic [31:0] usbPend_r;
  logic [31:0] usbPend_nxt;
  logic [31:0] usbEn_r;
  logic [13:0] fifoPend_r;
  logic [13:0] fifoPend_nxt;
  logic [13:0] fifoEn_r;
  logic [3:0] bus_error_limit_hit_r;
  logic [3:0] errCount_r;
  logic errOver_r;
  logic [31:0] prdata_r;
  logic slvErr_r;
  logic [7:0] usbVec_r;
  logic [7:0] fifoVec_r;
  logic usbLine_r;
  logic fifoLine_r;
  logic [7:0] fetch_r;
  logic [31:0] usbRaw;
  logic [13:0] fifoRaw;
  logic [31:0] usbActive;
  logic [31:0] fifoActive;
  logic errHit;
  logic setupPh;
  logic wrAcc;
  logic addrOk;
  logic [31:0] readMux;

  // lowest set index wins: priority 1 sits in slot 0
  function automatic logic [4:0] first_set(input logic [31:0] v);
    logic [4:0] idx;
    idx = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // hardware counts past the limit once, then holds the flag until a limit write
  assign errHit = busError && !errOver_r && (errCount_r >= bus_error_limit_hit_r);

  always_comb begin
    usbRaw = 32'h0000_0000;
    usbRaw[U_SETUP_DATA] = setupDataReady;
    usbRaw[U_SOF] = frameStart;
    usbRaw[U_SETUP_TOK] = setupTokenSeen;
    usbRaw[U_SUSP] = suspendRequest;
    usbRaw[U_URES] = busReset;
    usbRaw[U_HSPD] = highSpeedEntered;
    usbRaw[U_ACK] = controlHandshakeAcked;
    // ep0 in, ep0 out, ep1 in, ep1 out in that order
    usbRaw[U_EP01] = epInReady[0];
    usbRaw[U_EP01 + 1] = epOutHasData[0];
    usbRaw[U_EP01 + 2] = epInReady[1];
    usbRaw[U_EP01 + 3] = epOutHasData[1];
    usbRaw[U_EPBUF +: 4] = epBufferEvent;
    usbRaw[U_BULK_NAK] = inBulkNak;
    usbRaw[U_PING +: 6] = pingNak;
    usbRaw[U_ERRLIM] = errHit;
    usbRaw[U_ISO +: 4] = isoPidSequenceError;
  end

  always_comb begin
    fifoRaw = 14'h0000;
    fifoRaw[F_PF +: 4] = programmableLevelFlag;
    fifoRaw[F_EF +: 4] = bufferEmptyFlag;
    fifoRaw[F_FF +: 4] = bufferFullFlag;
    fifoRaw[F_DONE] = waveformEngineDone;
    fifoRaw[F_WAIT] = waveformEngineWait;
  end

  // apb decode
  assign setupPh = psel && !penable;
  assign wrAcc = psel && penable && pwrite;
  assign addrOk = hit(paddr, OFS_SETUP) || hit(paddr, OFS_USB_PEND) ||
                  hit(paddr, OFS_USB_EN) || hit(paddr, OFS_FIFO_PEND) ||
                  hit(paddr, OFS_FIFO_EN) || hit(paddr, OFS_VECTORS) ||
                  hit(paddr, OFS_ERR_LIMIT);

  // write one to clear; a new event in the same cycle keeps its bit set
  always_comb begin
    usbPend_nxt = usbPend_r;
    fifoPend_nxt = fifoPend_r;
    if (wrAcc && hit(paddr, OFS_USB_PEND)) begin
      usbPend_nxt = usbPend_nxt & ~pwdata;
    end
    if (wrAcc && hit(paddr, OFS_FIFO_PEND)) begin
      fifoPend_nxt = fifoPend_nxt & ~pwdata[13:0];
    end
    // reserved usb slots can never latch
    usbPend_nxt = (usbPend_nxt | usbRaw) & USB_VALID_MASK;
    fifoPend_nxt = fifoPend_nxt | fifoRaw;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      usbPend_r <= 32'h0000_0000;
      fifoPend_r <= 14'h0000;
    end else begin
      usbPend_r <= usbPend_nxt;
      fifoPend_r <= fifoPend_nxt;
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      setup_r <= RST_SETUP;
      usbEn_r <= RST_USB_EN;
      fifoEn_r <= RST_FIFO_EN;
    end else if (wrAcc) begin
      if (hit(paddr, OFS_SETUP)) begin
        setup_r <= pwdata[1:0];
      end
      if (hit(paddr, OFS_USB_EN)) begin
        usbEn_r <= pwdata & USB_VALID_MASK;
      end
      if (hit(paddr, OFS_FIFO_EN)) begin
        fifoEn_r <= pwdata[13:0];
      end
    end
  end

  // bus error counter; writing the limit restarts the count
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      bus_error_limit_hit_r <= RST_ERR_LIMIT;
      errCount_r <= 4'h0;
      errOver_r <= 1'b0;
    end else if (wrAcc && hit(paddr, OFS_ERR_LIMIT)) begin
      bus_error_limit_hit_r <= pwdata[ERR_W-1:0];
      errCount_r <= 4'h0;
      errOver_r <= 1'b0;
    end else if (busError && !errOver_r) begin
      // saturates so the count never wraps below the limit
      if (errCount_r != 4'hF) begin
        errCount_r <= errCount_r + 4'h1;
      end
      if (errHit) begin
        errOver_r <= 1'b1;
      end
    end
  end

  // only enabled pending sources compete for the vector
  assign usbActive = usbPend_r & usbEn_r;
  assign fifoActive = {18'h00000, fifoPend_r & fifoEn_r};

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      usbVec_r <= 8'h00;
      fifoVec_r <= FIFO_VEC_BASE;
      usbLine_r <= 1'b0;
      fifoLine_r <= 1'b0;
    end else begin
      usbVec_r <= {1'b0, first_set(usbActive), 2'b00};
      fifoVec_r <= FIFO_VEC_BASE | {1'b0, first_set(fifoActive), 2'b00};
      usbLine_r <= |usbActive;
      fifoLine_r <= |fifoActive;
    end
  end

  // the core itself vectors to 0043/0053; only the byte after the page moves
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fetch_r <= 8'h00;
    end else if (codeFetch) begin
      if (setup_r[BIT_USB_AV] && codeAddr == ADDR_USB_VEC) begin
        fetch_r <= usbVec_r;
      end else if (setup_r[BIT_FIFO_AV] && codeAddr == ADDR_FIFO_VEC) begin
        fetch_r <= fifoVec_r;
      end else begin
        fetch_r <= memData;
      end
    end
  end

  always_comb begin
    readMux = 32'h0000_0000;
    case (paddr)
      OFS_SETUP: readMux[1:0] = setup_r;
      OFS_USB_PEND: readMux = usbPend_r;
      OFS_USB_EN: readMux = usbEn_r;
      OFS_FIFO_PEND: readMux[13:0] = fifoPend_r;
      OFS_FIFO_EN: readMux[13:0] = fifoEn_r;
      OFS_VECTORS: begin
        readMux[7:0] = usbVec_r;
        readMux[POS_FIFO_VEC +: 8] = fifoVec_r;
      end
      OFS_ERR_LIMIT: begin
        readMux[ERR_W-1:0] = bus_error_limit_hit_r;
        readMux[POS_ERR_COUNT +: ERR_W] = errCount_r;
      end
      default: readMux = 32'h0000_0000;
    endcase
  end

  // read data and error are captured in the setup phase
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prdata_r <= 32'h0000_0000;
      slvErr_r <= 1'b0;
    end else if (setupPh) begin
      prdata_r <= pwrite ? 32'h0000_0000 : readMux;
      slvErr_r <= !addrOk;
    end
  end

  assign pready = 1'b1;
  assign pslverr = slvErr_r && psel && penable;
  assign prdata = prdata_r;
  assign fetchData = fetch_r;
  assign usbInterruptLine = usbLine_r;
  assign fifoInterruptLine = fifoLine_r;
  assign usbVectorCode = usbVec_r;
  assign fifoVectorCode = fifoVec_r;
endmodule

// ==== dv/uav_autovector_properties.sv ====
// Purpose: port checks for the autovector block
// Assumes: enable bits are tracked from apb writes
// Notes: bound to every instance of the block
`timescale 1ns/100ps
module uav_autovector_checker
  import uav_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // events
  input wire logic setupDataReady,
  input wire logic [3:0] programmableLevelFlag,
  // fetch and vectors
  input wire logic codeFetch,
  input wire logic [15:0] codeAddr,
  input wire logic [7:0] memData,
  input wire logic [7:0] fetchData,
  input wire logic usbInterruptLine,
  input wire logic fifoInterruptLine,
  input wire logic [7:0] usbVectorCode,
  input wire logic [7:0] fifoVectorCode
);
  logic [1:0] avEn_r;
  logic usbEn0_r;
  logic fifoEn0_r;
  wire logic apbWrite = psel && penable && pwrite;
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      avEn_r <= 2'h0;
      usbEn0_r <= 1'b0;
      fifoEn0_r <= 1'b0;
    end else if (apbWrite) begin
      if (paddr == OFS_SETUP) avEn_r <= pwdata[1:0];
      if (paddr == OFS_USB_EN) usbEn0_r <= pwdata[0];
      if (paddr == OFS_FIFO_EN) fifoEn0_r <= pwdata[0];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_usb_aligned: assert property (usbInterruptLine |->
    usbVectorCode[1:0] == 2'h0 && !usbVectorCode[7]) else $error("usb vector off grid");
  a_usb_reserved: assert property (usbInterruptLine |->
    !(usbVectorCode inside {8'h1C, 8'h44, 8'h64, 8'h68, 8'h6C})) else $error("reserved code");
  a_fifo_span: assert property (fifoInterruptLine |-> fifoVectorCode[1:0] == 2'h0 &&
    fifoVectorCode inside {[8'h80:8'hB4]}) else $error("fifo vector out of span");
  a_setup_first: assert property (setupDataReady && usbEn0_r |->
    ##2 usbInterruptLine && usbVectorCode == 8'h00) else $error("setup data not on top");
  a_level_first: assert property (programmableLevelFlag[0] && fifoEn0_r |->
    ##2 fifoInterruptLine && fifoVectorCode == 8'h80) else $error("level flag not on top");
  a_usb_swap: assert property (codeFetch && codeAddr == ADDR_USB_VEC && avEn_r[0] |=>
    fetchData == $past(usbVectorCode)) else $error("usb byte not substituted");
  a_fifo_swap: assert property (codeFetch && codeAddr == ADDR_FIFO_VEC && avEn_r[1] |=>
    fetchData == $past(fifoVectorCode)) else $error("fifo byte not substituted");
  a_plain_fetch: assert property (codeFetch
    && !(codeAddr == ADDR_USB_VEC && avEn_r[0]) && !(codeAddr == ADDR_FIFO_VEC && avEn_r[1])
    |=> fetchData == $past(memData)) else $error("memory byte altered");
  a_bad_offset: assert property (psel && penable && paddr > OFS_ERR_LIMIT |-> pslverr)
    else $error("unmapped access not flagged");
endmodule
bind uav_autovector uav_autovector_checker u_chk (.*);

// ==== dv/uav_cpu_model.sv ====
// Purpose: processor side of the code fetch path
// Assumes: code memory of 256 bytes, mirrored
// Notes: bytes read as inverted between fetches
`timescale 1ns/100ps
module uav_cpu_model (
  // clock
  input wire logic mclk,
  // fetch path
  output logic codeFetch,
  output logic [15:0] codeAddr,
  output logic [7:0] memData,
  input wire logic [7:0] fetchData
);
  logic [7:0] mem [0:255];
  initial begin
    codeFetch = 1'b0;
    codeAddr = 16'h0000;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    mem[8'h43] = 8'h02; // jump opcode at the usb entry
    mem[8'h53] = 8'h02; // jump opcode at the fifo entry
  end
  // released bus must not look like the last byte
  assign memData = codeFetch ? mem[codeAddr[7:0]] : ~mem[codeAddr[7:0]];
  task automatic fetch(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk);
    codeFetch <= 1'b1;
    codeAddr <= a;
    @(posedge mclk);
    codeFetch <= 1'b0;
    @(negedge mclk);
    d = fetchData;
  endtask
endmodule

// ==== dv/tb_usb_fifo_interrupt_autovector.sv ====
// Purpose: self-checking bench for the autovector block
// Assumes: zero-wait apb, two-edge event latency
// Notes: priorities walked from lowest to highest
`timescale 1ns/100ps
module tb_usb_fifo_interrupt_autovector;
  import uav_pkg::*;
  logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, se;
  logic codeFetch, usbLine, fifoLine;
  logic [7:0] paddr, usbVec, fifoVec, fetchData, memData, b;
  logic [15:0] codeAddr;
  logic [31:0] pwdata, prdata, uP, rd;
  logic [13:0] fP;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  uav_autovector u_dut (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .setupDataReady(uP[0]), .frameStart(uP[1]), .setupTokenSeen(uP[2]),
    .suspendRequest(uP[3]), .busReset(uP[4]), .highSpeedEntered(uP[5]),
    .controlHandshakeAcked(uP[6]), .epInReady({uP[10], uP[8]}),
    .epOutHasData({uP[11], uP[9]}), .epBufferEvent(uP[15:12]), .inBulkNak(uP[16]),
    .pingNak(uP[23:18]), .busError(uP[24]), .isoPidSequenceError(uP[31:28]),
    .programmableLevelFlag(fP[3:0]), .bufferEmptyFlag(fP[7:4]), .bufferFullFlag(fP[11:8]),
    .waveformEngineDone(fP[12]), .waveformEngineWait(fP[13]), .codeFetch(codeFetch),
    .codeAddr(codeAddr), .memData(memData), .fetchData(fetchData),
    .usbInterruptLine(usbLine), .fifoInterruptLine(fifoLine),
    .usbVectorCode(usbVec), .fifoVectorCode(fifoVec)
  );
  uav_cpu_model u_cpu (
    .mclk(mclk), .codeFetch(codeFetch), .codeAddr(codeAddr), .memData(memData),
    .fetchData(fetchData)
  );
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pulse for one cycle, then wait out the two-edge latency
  task automatic ev(input logic [31:0] u, input logic [13:0] f);
    @(posedge mclk);
    uP <= u;
    fP <= f;
    @(posedge mclk);
    uP <= '0;
    fP <= '0;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic t_reset();
    apb(1'b0, OFS_VECTORS, 0);
    chk(rd, 32'h0000_8000);
    apb(1'b0, OFS_ERR_LIMIT, 0);
    chk(rd[3:0], 4);
    apb(1'b0, 8'h1C, 0);
    chk(rd, 32'h0000_0000);
    chk(se, 1'b1);
  endtask
  task automatic t_usb();
    apb(1'b1, OFS_USB_EN, 32'hFFFF_FFFF);
    // only slots that carry a source may hold an enable
    apb(1'b0, OFS_USB_EN, 0);
    chk(rd, 32'hF1FD_FF7F);
    for (int i = 31; i >= 0; i--) begin
      if (USB_VALID_MASK[i] && i != U_ERRLIM) begin
        ev(32'h1 << i, '0);
        chk({usbLine, usbVec}, {1'b1, 8'(4 * i)});
      end
    end
    apb(1'b1, OFS_USB_PEND, 32'hFFFF_FFFF);
    ev('0, '0);
    chk(usbLine, 0);
  endtask
  task automatic t_err();
    repeat (4) begin
      ev(32'h1 << U_ERRLIM, '0);
      chk(usbLine, 0);
    end
    ev(32'h1 << U_ERRLIM, '0);
    chk({usbLine, usbVec}, {1'b1, 8'h60});
  endtask
  task automatic t_fifo();
    apb(1'b1, OFS_FIFO_EN, 32'h3FFF);
    for (int i = 13; i >= 0; i--) begin
      ev('0, 14'h1 << i);
      chk({fifoLine, fifoVec}, {1'b1, FIFO_VEC_BASE + 8'(4 * i)});
    end
  endtask
  task automatic t_fetch();
    logic [7:0] x;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_SETUP, s);
      for (int a = 'h43; a < 'h56; a++) begin
        u_cpu.fetch(16'(a), b);
        x = u_cpu.mem[a];
        if (a == 'h45 && s[0]) x = 8'h60;
        if (a == 'h55 && s[1]) x = 8'h80;
        chk(b, x);
      end
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    uP = '0;
    fP = '0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_usb();
    t_err();
    t_fifo();
    t_fetch();
    report_and_stop();
  end
endmodule
